// >>> hpmix_pkg.sv
// hpmix_pkg: register map, field layout, reset values and types of the
// headphone output mix register bank.
// assumes a single 20 MHz core clock and an APB register bus.
package hpmix_pkg;

    // printed offsets are not all multiples of four: they are indices
    localparam logic [7:0] HPMIX_IDX_RSVD_A = 8'h30;
    localparam logic [7:0] HPMIX_IDX_RAMP_HPL = 8'h31;
    localparam logic [7:0] HPMIX_IDX_RDAC_HPL = 8'h32;
    localparam logic [7:0] HPMIX_IDX_HPL_LEVEL = 8'h33;
    localparam logic [7:0] HPMIX_IDX_RSVD_B = 8'h34;
    localparam logic [7:0] HPMIX_IDX_LAMP_COM = 8'h35;
    localparam logic [7:0] HPMIX_IDX_LDAC_COM = 8'h36;
    localparam logic [7:0] HPMIX_IDX_RSVD_C = 8'h37;
    localparam logic [7:0] HPMIX_IDX_RAMP_COM = 8'h38;
    localparam logic [7:0] HPMIX_IDX_RDAC_COM = 8'h39;
    localparam logic [7:0] HPMIX_IDX_IRQ_STATUS = 8'h3A;
    localparam logic [7:0] HPMIX_IDX_IRQ_MASK = 8'h3B;
    localparam int HPMIX_IDX_FIRST = 48;
    localparam int HPMIX_NUM_REGS = 12;

    // field positions
    localparam int HPMIX_ROUTE_BIT = 7;
    localparam int HPMIX_ATTN_MSB = 6;
    localparam int HPMIX_LEVEL_MSB = 7;
    localparam int HPMIX_LEVEL_LSB = 4;
    localparam int HPMIX_UNMUTE_BIT = 3;
    localparam int HPMIX_HIZ_BIT = 2;
    localparam int HPMIX_PENDING_BIT = 1;
    localparam int HPMIX_POWER_BIT = 0;

    // reset values
    localparam logic [7:0] HPMIX_RST_MIX = 8'h00;
    localparam logic [7:0] HPMIX_RST_LEVEL = 8'h06;
    localparam logic [7:0] HPMIX_RST_RSVD = 8'h00;
    localparam logic [6:0] HPMIX_ATTN_MUTE_FIRST = 7'h76;
    localparam logic [3:0] HPMIX_LEVEL_MAX = 4'h9;

    // gain stepping: one 0.5 dB step per tick
    localparam int HPMIX_CLK_HZ = 20000000;
    localparam int HPMIX_STEP_US = 5;
    localparam int HPMIX_STEP_CYCLES = HPMIX_CLK_HZ / 1000000 * HPMIX_STEP_US;

    // irq status bits
    localparam int HPMIX_IRQ_APPLIED = 0;
    localparam int HPMIX_IRQ_BADLEVEL = 1;
    localparam int HPMIX_IRQ_RSVDWR = 2;

    typedef struct packed {
        logic route;
        logic [6:0] attn;
        logic attn_mute;
    } hpmix_src_t;

    typedef struct packed {
        logic [3:0] level;
        logic unmute;
        logic hiz_when_down;
        logic power_up;
    } hpmix_drv_t;

endpackage : hpmix_pkg

// >>> hpmix_regs.sv
// hpmix_regs: APB register bank for left headphone and left common-mode mix.
// assumes synchronous APB master on clk; analog side samples outputs directly.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - bit 7 of right-amp-to-headphone register routes right amplifier into headphone mix
// - bit 7 of right-DAC-to-headphone register routes right DAC into headphone mix
// - each mix register holds read/write 7-bit attenuation code in bits 6..0
// - attenuation codes step down from 0 dB; codes 118 to 127 mute
// - level bits 7..4 boost 0 to 9 dB, reset 0000
// - level bit 3 clear mutes headphone driver, set unmutes; resets 0
// - level bit 2 set gives high-impedance power-down, clear weak drive; resets 1
// - level bit 1 read-only, 1 while headphone gains pending; resets 1
// - level bit 0 set fully powers headphone driver; resets 0
// - four registers feed common-mode mix, bit 7 gates each connection
// - every mix register resets with route clear and attenuation zero
module hpmix_regs
    import hpmix_pkg::*;
#(
    parameter int STEP_CYCLES = HPMIX_STEP_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output hpmix_src_t hp_right_amp,
    output hpmix_src_t hp_right_dac,
    output hpmix_src_t com_left_amp,
    output hpmix_src_t com_left_dac,
    output hpmix_src_t com_right_amp,
    output hpmix_src_t com_right_dac,
    output hpmix_drv_t hp_drive,
    output logic irq
);

    // refuse at elaboration: a wider count would wrap the 16-bit tick counter
    if (STEP_CYCLES < 1 || STEP_CYCLES > 65535) begin : g_bad_step
        $error("STEP_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    typedef enum logic [1:0] {
        HPMIX_IDLE = 2'b00,
        HPMIX_STEP = 2'b01
    } hpmix_ramp_t;

    localparam int NMIX = 6;
    // index into mix[]: 0 rampHP, 1 rdacHP, 2 lampC, 3 ldacC, 4 rampC, 5 rdacC
    logic [7:0] mix [NMIX];
    logic [7:0] next_mix [NMIX];
    logic [7:0] level;
    logic [7:0] next_level;
    logic [7:0] rsvd [3];
    logic [7:0] next_rsvd [3];
    logic [2:0] irq_status;
    logic [2:0] next_irq_status;
    logic [2:0] irq_mask;
    logic [2:0] next_irq_mask;
    logic [6:0] applied [2];
    logic [6:0] next_applied [2];
    logic [15:0] tick_cnt;
    logic [15:0] next_tick_cnt;
    hpmix_ramp_t ramp;
    hpmix_ramp_t next_ramp;
    logic pending;
    logic next_pending;
    logic [31:0] next_prdata;

    logic access;
    logic wr;
    logic aligned;
    logic [7:0] idx;
    logic mapped;
    logic tick;
    logic match;
    logic applied_event;

    assign access = psel && penable;
    assign aligned = paddr[1:0] == 2'b00;
    assign idx = {2'b00, paddr[7:2]};
    assign mapped = aligned && paddr[11:8] == 4'h0 && idx >= HPMIX_IDX_RSVD_A
                    && idx <= HPMIX_IDX_IRQ_MASK;
    assign wr = access && pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // register storage

    always_comb begin
        for (int i = 0; i < NMIX; i++) begin
            next_mix[i] = mix[i];
        end
        for (int i = 0; i < 3; i++) begin
            next_rsvd[i] = rsvd[i];
        end
        next_level = level;
        next_irq_mask = irq_mask;
        if (wr) begin
            unique case (idx)
                HPMIX_IDX_RAMP_HPL: next_mix[0] = pwdata[7:0];
                HPMIX_IDX_RDAC_HPL: next_mix[1] = pwdata[7:0];
                HPMIX_IDX_LAMP_COM: next_mix[2] = pwdata[7:0];
                HPMIX_IDX_LDAC_COM: next_mix[3] = pwdata[7:0];
                HPMIX_IDX_RAMP_COM: next_mix[4] = pwdata[7:0];
                HPMIX_IDX_RDAC_COM: next_mix[5] = pwdata[7:0];
                // pending bit is hardware owned; writes to it are dropped
                HPMIX_IDX_HPL_LEVEL: next_level = {pwdata[7:2], 1'b0, pwdata[0]};
                HPMIX_IDX_RSVD_A: next_rsvd[0] = pwdata[7:0];
                HPMIX_IDX_RSVD_B: next_rsvd[1] = pwdata[7:0];
                HPMIX_IDX_RSVD_C: next_rsvd[2] = pwdata[7:0];
                HPMIX_IDX_IRQ_MASK: next_irq_mask = pwdata[2:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NMIX; i++) begin
                mix[i] <= HPMIX_RST_MIX;
            end
            for (int i = 0; i < 3; i++) begin
                rsvd[i] <= HPMIX_RST_RSVD;
            end
            level <= HPMIX_RST_LEVEL;
            irq_mask <= 3'h0;
        end else begin
            for (int i = 0; i < NMIX; i++) begin
                mix[i] <= next_mix[i];
            end
            for (int i = 0; i < 3; i++) begin
                rsvd[i] <= next_rsvd[i];
            end
            level <= next_level;
            irq_mask <= next_irq_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // gain stepping toward programmed headphone attenuations

    // applied gain walks one code per tick to avoid zipper noise
    assign tick = tick_cnt == 16'(STEP_CYCLES - 1);
    assign match = applied[0] == mix[0][HPMIX_ATTN_MSB:0]
                   && applied[1] == mix[1][HPMIX_ATTN_MSB:0];

    always_comb begin
        next_ramp = ramp;
        next_tick_cnt = tick_cnt;
        next_pending = pending;
        applied_event = 1'b0;
        for (int i = 0; i < 2; i++) begin
            next_applied[i] = applied[i];
        end
        unique case (ramp)
            HPMIX_IDLE: begin
                next_tick_cnt = 16'h0000;
                if (!match) begin
                    next_ramp = HPMIX_STEP;
                end
            end
            HPMIX_STEP: begin
                next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
                if (tick) begin
                    for (int i = 0; i < 2; i++) begin
                        if (applied[i] < mix[i][HPMIX_ATTN_MSB:0]) begin
                            next_applied[i] = applied[i] + 7'h01;
                        end else if (applied[i] > mix[i][HPMIX_ATTN_MSB:0]) begin
                            next_applied[i] = applied[i] - 7'h01;
                        end
                    end
                end
                if (match) begin
                    next_ramp = HPMIX_IDLE;
                end
            end
        endcase
        // new write sets pending; set wins over the match clear
        if (wr && (idx == HPMIX_IDX_RAMP_HPL || idx == HPMIX_IDX_RDAC_HPL
                   || idx == HPMIX_IDX_HPL_LEVEL)) begin
            next_pending = 1'b1;
        end else if (pending && match && ramp == HPMIX_IDLE) begin
            next_pending = 1'b0;
            applied_event = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ramp <= HPMIX_IDLE;
            tick_cnt <= 16'h0000;
            pending <= 1'b1;
            applied[0] <= 7'h00;
            applied[1] <= 7'h00;
        end else begin
            ramp <= next_ramp;
            tick_cnt <= next_tick_cnt;
            pending <= next_pending;
            applied[0] <= next_applied[0];
            applied[1] <= next_applied[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts and read data

    always_comb begin
        next_irq_status = irq_status;
        if (wr && idx == HPMIX_IDX_IRQ_STATUS) begin
            next_irq_status = irq_status & ~pwdata[2:0];
        end
        // events win over a simultaneous clear
        if (applied_event) begin
            next_irq_status[HPMIX_IRQ_APPLIED] = 1'b1;
        end
        if (wr && idx == HPMIX_IDX_HPL_LEVEL
            && pwdata[HPMIX_LEVEL_MSB:HPMIX_LEVEL_LSB] > HPMIX_LEVEL_MAX) begin
            next_irq_status[HPMIX_IRQ_BADLEVEL] = 1'b1;
        end
        if (wr && (idx == HPMIX_IDX_RSVD_A || idx == HPMIX_IDX_RSVD_B
                   || idx == HPMIX_IDX_RSVD_C)) begin
            next_irq_status[HPMIX_IRQ_RSVDWR] = 1'b1;
        end
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            unique case (idx)
                HPMIX_IDX_RAMP_HPL: next_prdata[7:0] = mix[0];
                HPMIX_IDX_RDAC_HPL: next_prdata[7:0] = mix[1];
                HPMIX_IDX_LAMP_COM: next_prdata[7:0] = mix[2];
                HPMIX_IDX_LDAC_COM: next_prdata[7:0] = mix[3];
                HPMIX_IDX_RAMP_COM: next_prdata[7:0] = mix[4];
                HPMIX_IDX_RDAC_COM: next_prdata[7:0] = mix[5];
                HPMIX_IDX_HPL_LEVEL: next_prdata[7:0] = {level[7:2], pending, level[0]};
                HPMIX_IDX_RSVD_A: next_prdata[7:0] = rsvd[0];
                HPMIX_IDX_RSVD_B: next_prdata[7:0] = rsvd[1];
                HPMIX_IDX_RSVD_C: next_prdata[7:0] = rsvd[2];
                HPMIX_IDX_IRQ_STATUS: next_prdata[2:0] = irq_status;
                HPMIX_IDX_IRQ_MASK: next_prdata[2:0] = irq_mask;
                default: next_prdata = 32'h0000_0000;
            endcase
            if (!mapped) begin
                next_prdata = 32'h0000_0000;
            end
        end else if (access) begin
            next_prdata = prdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_status <= 3'h0;
            prdata <= 32'h0000_0000;
        end else begin
            irq_status <= next_irq_status;
            prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // analog control outputs

    logic [7:0] drv_src [NMIX];
    hpmix_src_t src_out [NMIX];
    always_comb begin
        drv_src[0] = {mix[0][7], applied[0]};
        drv_src[1] = {mix[1][7], applied[1]};
        for (int i = 2; i < NMIX; i++) begin
            drv_src[i] = mix[i];
        end
    end

    for (genvar g = 0; g < NMIX; g++) begin : g_src
        assign src_out[g].route = drv_src[g][HPMIX_ROUTE_BIT];
        assign src_out[g].attn = drv_src[g][HPMIX_ATTN_MSB:0];
        assign src_out[g].attn_mute = drv_src[g][HPMIX_ATTN_MSB:0] >= HPMIX_ATTN_MUTE_FIRST;
    end

    assign hp_right_amp = src_out[0];
    assign hp_right_dac = src_out[1];
    assign com_left_amp = src_out[2];
    assign com_left_dac = src_out[3];
    assign com_right_amp = src_out[4];
    assign com_right_dac = src_out[5];
    assign hp_drive.level = level[HPMIX_LEVEL_MSB:HPMIX_LEVEL_LSB];
    assign hp_drive.unmute = level[HPMIX_UNMUTE_BIT];
    assign hp_drive.hiz_when_down = level[HPMIX_HIZ_BIT];
    assign hp_drive.power_up = level[HPMIX_POWER_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    property p_route_follows_write;
        @(posedge clk) disable iff (!arst_n)
        (wr && idx == HPMIX_IDX_RAMP_HPL) |=> hp_right_amp.route == $past(pwdata[7]);
    endproperty
    a_route_follows_write: assert property (p_route_follows_write)
        else $error("route bit not taken from write");

    property p_dac_route;
        @(posedge clk) disable iff (!arst_n)
        (wr && idx == HPMIX_IDX_RDAC_HPL) |=> hp_right_dac.route == $past(pwdata[7]);
    endproperty
    a_dac_route: assert property (p_dac_route)
        else $error("dac route bit wrong");

    property p_com_attn;
        @(posedge clk) disable iff (!arst_n)
        (wr && idx == HPMIX_IDX_RDAC_COM) |=> com_right_dac.attn == $past(pwdata[6:0]);
    endproperty
    a_com_attn: assert property (p_com_attn)
        else $error("common attenuation not stored");

    property p_mute_range;
        @(posedge clk) disable iff (!arst_n)
        hp_right_dac.attn_mute == (hp_right_dac.attn > 7'h75);
    endproperty
    a_mute_range: assert property (p_mute_range)
        else $error("mute code range wrong");

    property p_level_write;
        @(posedge clk) disable iff (!arst_n)
        (wr && idx == HPMIX_IDX_HPL_LEVEL) |=> hp_drive.level == $past(pwdata[7:4])
            && hp_drive.unmute == $past(pwdata[3]) && hp_drive.power_up == $past(pwdata[0]);
    endproperty
    a_level_write: assert property (p_level_write)
        else $error("level fields not stored");

    property p_pending_set;
        @(posedge clk) disable iff (!arst_n)
        (wr && idx == HPMIX_IDX_RDAC_HPL) |=> pending;
    endproperty
    a_pending_set: assert property (p_pending_set)
        else $error("pending not set on gain write");

    property p_pending_clear;
        @(posedge clk) disable iff (!arst_n)
        (pending && !wr) ##1 (ramp == HPMIX_IDLE && match && !wr) |=> !pending;
    endproperty
    a_pending_clear: assert property (p_pending_clear)
        else $error("pending not cleared after apply");

    property p_hiz_write;
        @(posedge clk) disable iff (!arst_n)
        (wr && idx == HPMIX_IDX_HPL_LEVEL) |=> hp_drive.hiz_when_down == $past(pwdata[2]);
    endproperty
    a_hiz_write: assert property (p_hiz_write)
        else $error("power-down drive bit wrong");

    property p_rsvd_flag;
        @(posedge clk) disable iff (!arst_n)
        (wr && idx == HPMIX_IDX_RSVD_B) |=> irq_status[HPMIX_IRQ_RSVDWR];
    endproperty
    a_rsvd_flag: assert property (p_rsvd_flag)
        else $error("reserved write not flagged");

    property p_com_route;
        @(posedge clk) disable iff (!arst_n)
        (wr && idx == HPMIX_IDX_LAMP_COM) |=> com_left_amp.route == $past(pwdata[7]);
    endproperty
    a_com_route: assert property (p_com_route)
        else $error("common route bit wrong");

endmodule : hpmix_regs

// >>> tb_top.sv
// tb_top: self-checking bench for the headphone output mix register bank.
// assumes hpmix_pkg and hpmix_regs are compiled first; one 20 MHz clock.
`timescale 1ns/1ns

`define CHECK(a, e) check_val(32'(a), 32'(e))

module tb_top;
    import hpmix_pkg::*;

    localparam int STEP = 2;
    localparam int LIMIT = 20000;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    hpmix_src_t hp_right_amp, hp_right_dac, com_left_amp, com_left_dac;
    hpmix_src_t com_right_amp, com_right_dac;
    hpmix_drv_t hp_drive;
    logic irq;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;

    hpmix_regs #(.STEP_CYCLES(STEP)) i_hpmix_regs (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hp_right_amp(hp_right_amp), .hp_right_dac(hp_right_dac),
        .com_left_amp(com_left_amp), .com_left_dac(com_left_dac),
        .com_right_amp(com_right_amp), .com_right_dac(com_right_dac),
        .hp_drive(hp_drive), .irq(irq)
    );

    always #25 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    function automatic void check_val(logic [31:0] a, logic [31:0] e);
        compares++;
        if (a !== e) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, a, e);
        end
    endfunction : check_val

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    always @(posedge clk) begin
        cycles++;
        if (cycles >= LIMIT) begin
            bad_count++;
            end_of_test();
        end
    end

    // index to byte address: printed offsets are word indices
    function automatic logic [11:0] ba(logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : ba

    // one apb transfer; an idle edge first keeps back-to-back calls clean
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) `CHECK(pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic settle();
        @(posedge clk);
        #1;
    endtask : settle

    // poll the level register until the pending status drops
    task automatic wait_applied();
        for (int i = 0; i < 400; i++) begin
            apb(1'b0, ba(HPMIX_IDX_HPL_LEVEL), 32'h0);
            if (rd[HPMIX_PENDING_BIT] === 1'b0) break;
        end
        `CHECK(rd[HPMIX_PENDING_BIT], 1'b0);
    endtask : wait_applied

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] idx;
        wait_applied();
        for (int i = 0; i < 10; i++) begin
            idx = 8'(HPMIX_IDX_FIRST + i);
            apb(1'b0, ba(idx), 32'h0);
            // pending has already cleared, so the level register reads 0x04
            `CHECK(rd, (idx == HPMIX_IDX_HPL_LEVEL) ? 32'h04 : 32'h00);
        end
        apb(1'b0, ba(HPMIX_IDX_IRQ_MASK), 32'h0);
        `CHECK(rd, 32'h0);
        `CHECK(hp_drive, {4'h0, 1'b0, 1'b1, 1'b0});
        $display("test reset done");
    endtask : t_reset

    task automatic t_routing();
        logic [7:0] ids [6] = '{8'h31, 8'h32, 8'h35, 8'h36, 8'h38, 8'h39};
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, ba(ids[i]), {24'h0, 8'h80 | ids[i]});
        end
        settle();
        `CHECK(hp_right_amp.route, 1'b1);
        `CHECK(hp_right_dac.route, 1'b1);
        `CHECK(com_left_amp, {1'b1, 7'h35, 1'b0});
        `CHECK(com_left_dac, {1'b1, 7'h36, 1'b0});
        `CHECK(com_right_amp, {1'b1, 7'h38, 1'b0});
        `CHECK(com_right_dac, {1'b1, 7'h39, 1'b0});
        apb(1'b0, ba(HPMIX_IDX_HPL_LEVEL), 32'h0);
        `CHECK(rd[HPMIX_PENDING_BIT], 1'b1);
        wait_applied();
        `CHECK(hp_right_amp, {1'b1, 7'h31, 1'b0});
        `CHECK(hp_right_dac, {1'b1, 7'h32, 1'b0});
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ba(ids[i]), 32'h0);
            `CHECK(rd, {24'h0, 8'h80 | ids[i]});
        end
        apb(1'b1, ba(8'h38), 32'h0000_0038);
        settle();
        `CHECK(com_right_amp, {1'b0, 7'h38, 1'b0});
        $display("test routing done");
    endtask : t_routing

    task automatic t_mute_edge();
        apb(1'b1, ba(HPMIX_IDX_RDAC_HPL), 32'h0000_0075);
        wait_applied();
        `CHECK(hp_right_dac, {1'b0, 7'h75, 1'b0});
        apb(1'b1, ba(HPMIX_IDX_RDAC_HPL), 32'h0000_0076);
        wait_applied();
        `CHECK(hp_right_dac, {1'b0, 7'h76, 1'b1});
        apb(1'b1, ba(HPMIX_IDX_RDAC_HPL), 32'h0000_007F);
        wait_applied();
        `CHECK(hp_right_dac, {1'b0, 7'h7F, 1'b1});
        $display("test mute threshold done");
    endtask : t_mute_edge

    task automatic t_level();
        // bit 1 written as one must not stick: it is status only
        apb(1'b1, ba(HPMIX_IDX_HPL_LEVEL), 32'h0000_009F);
        settle();
        `CHECK(hp_drive, {4'h9, 1'b1, 1'b1, 1'b1});
        wait_applied();
        `CHECK(rd, 32'h0000_009D);
        apb(1'b1, ba(HPMIX_IDX_HPL_LEVEL), 32'h0000_0000);
        settle();
        `CHECK(hp_drive, {4'h0, 1'b0, 1'b0, 1'b0});
        wait_applied();
        `CHECK(rd, 32'h0);
        $display("test level done");
    endtask : t_level

    task automatic t_irq_bus();
        apb(1'b0, ba(HPMIX_IDX_IRQ_STATUS), 32'h0);
        `CHECK(rd[HPMIX_IRQ_APPLIED], 1'b1);
        apb(1'b1, ba(HPMIX_IDX_IRQ_MASK), 32'h0);
        apb(1'b1, ba(HPMIX_IDX_IRQ_STATUS), 32'h7);
        apb(1'b0, ba(HPMIX_IDX_IRQ_STATUS), 32'h0);
        `CHECK(rd, 32'h0);
        // software misuse on purpose: reserved register written
        apb(1'b1, ba(HPMIX_IDX_RSVD_B), 32'h0000_005A);
        apb(1'b0, ba(HPMIX_IDX_RSVD_B), 32'h0);
        `CHECK(rd, 32'h0000_005A);
        apb(1'b0, ba(HPMIX_IDX_IRQ_STATUS), 32'h0);
        `CHECK(rd[HPMIX_IRQ_RSVDWR], 1'b1);
        settle();
        `CHECK(irq, 1'b0);
        apb(1'b1, ba(HPMIX_IDX_IRQ_MASK), 32'h4);
        settle();
        `CHECK(irq, 1'b1);
        apb(1'b1, ba(HPMIX_IDX_IRQ_STATUS), 32'h4);
        settle();
        `CHECK(irq, 1'b0);
        // reserved level code is flagged
        apb(1'b1, ba(HPMIX_IDX_HPL_LEVEL), 32'h0000_00A4);
        apb(1'b0, ba(HPMIX_IDX_IRQ_STATUS), 32'h0);
        `CHECK(rd[HPMIX_IRQ_BADLEVEL], 1'b1);
        apb(1'b1, ba(HPMIX_IDX_HPL_LEVEL), 32'h0000_0004);
        apb(1'b1, ba(8'hF0), 32'h0000_00FF);
        `CHECK(err, 1'b1);
        apb(1'b0, ba(8'hF0), 32'h0);
        `CHECK(rd, 32'h0);
        `CHECK(err, 1'b1);
        $display("test irq and bus done");
    endtask : t_irq_bus

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        @(posedge clk);
        #1;
        `CHECK(hp_drive, {4'h0, 1'b0, 1'b1, 1'b0});
        `CHECK(irq, 1'b0);
        `CHECK(i_hpmix_regs.pending, 1'b1);
        @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_routing();
        t_mute_edge();
        t_level();
        t_irq_bus();
        end_of_test();
    end

endmodule : tb_top
